// file: core/qaw_watchdog.sv
// qaw_watchdog: question-answer watchdog sequencing, checking and flags
// Overview of operation
// RULE1: code 0xa starts a sequence with answer
// RULE2: timing starts at chip select rising edge
// RULE3: start accepted on code; wrong value counts error
// RULE4: start while running counts error, discarded
// RULE5: answer code 0x7 ignored when idle
// RULE6: timing off: correct answer clears errors, advances
// RULE7: wrong answer counts error and advances sequence
// RULE8: failed frame check discards command entirely
// RULE9: answer due within window after previous frame
// RULE10: late or wrong answer counts, advances
// RULE11: sequence change restarts window counter
// RULE12: code 0x5 stops; ignored when idle
// RULE13: other codes while running count error only
// RULE14: wrong answer flag sticky until cleared
// RULE15: late answer flag sticky until cleared
// RULE16: error limit flag set at count four
// RULE17: sequence advances on start, answer, timeout
// RULE18: start clears error counter
// RULE19: good answer clears errors below limit only
// RULE20: clearing limit flag clears error counter
// RULE21: expected value stepped by x^4+x^3+1
// RULE22: sequence counter has sixteen values
// RULE23: diagnostic low while any flag set
// RULE24: error counter saturates at four
module qaw_watchdog
	import qaw_pkg::*;
#(
	parameter int TMO_W = 16  // width of the timeout window count
) (
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	input  wire qaw_cmd_s         cmd_in,               // command at frame end
	input  wire logic             chip_select_n_in,     // serial chip select
	input  wire logic             timeout_enable_in,    // answer timing on
	input  wire logic [TMO_W-1:0] timeout_limit_in,     // window in cycles
	input  wire qaw_clr_s         clear_in,             // flag clear strobes
	output qaw_flags_s            flags_out,            // sticky flags
	output logic                  diag_n_out,           // low while a flag is set
	output logic                  running_out,          // sequence active
	output logic [3:0]            seq_count_out,        // current sequence number
	output logic [3:0]            prev_expected_out,    // previous expected value
	output logic [2:0]            error_count_out       // error accumulation
);

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	if (TMO_W < 2 || TMO_W > 31) begin : g_bad_width
		$error("qaw_watchdog: TMO_W out of range");
	end

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// four galois shifts of the previous expected value
	function automatic logic [3:0] next_expected(input logic [3:0] prev);
		logic [3:0] s;
		s = prev;
		for (int i = 0; i < QAW_STEP_SHIFTS; i++) begin
			s = {s[2:0], 1'b0} ^ (s[3] ? QAW_POLY_TAPS : 4'h0);  // [RULE21]
		end
		return s;
	endfunction

	// add events to the error counter, never past the ceiling
	function automatic logic [2:0] err_add(input logic [2:0] cur, input logic [1:0] inc);
		logic [3:0] sum;
		sum = {1'b0, cur} + {2'b00, inc};
		return (sum >= {1'b0, QAW_ERR_LIMIT}) ? QAW_ERR_LIMIT : sum[2:0];  // [RULE24]
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic             running_reg;      // sequence active
	logic [3:0]       seq_reg;          // sequence counter
	logic [3:0]       prev_reg;         // previous expected value
	logic [2:0]       err_reg;          // error accumulation counter
	logic             wait_cs_reg;      // window held until chip select rises
	logic             cs_n_reg;         // chip select one cycle ago
	qaw_flags_s       flags_reg;        // sticky flags
	logic             diag_n_reg;       // diagnostic output

	logic             cmd_ok;           // command survived the frame check
	logic             is_start;         // accepted start from idle
	logic             is_restart;       // start while running
	logic             is_answer;        // accepted answer while running
	logic             is_stop;          // accepted stop while running
	logic             is_other;         // unknown code while running
	logic [3:0]       expected;         // value due for the next answer
	logic             match;            // answer value matches
	logic             expire;           // raw window end from the timer
	logic             tmo_hit;          // window end that counts as timeout
	logic             cs_rise;          // chip select released
	logic             seq_change;       // sequence counter moves this cycle
	logic             tmr_run;          // timer counts this cycle
	logic [1:0]       err_inc;          // error events this cycle
	logic [2:0]       err_base;         // counter after software clear

	// ****************************************************************
	// command decode
	// ****************************************************************
	// a frame that failed its check never reaches the decoder
	assign cmd_ok     = cmd_in.valid && cmd_in.crc_ok;                    // [RULE8]
	assign is_start   = cmd_ok && !running_reg
	                    && cmd_in.command_code == QAW_CODE_START;           // [RULE1] [RULE3]
	assign is_restart = cmd_ok && running_reg
	                    && cmd_in.command_code == QAW_CODE_START;           // [RULE4]
	assign is_answer  = cmd_ok && running_reg
	                    && cmd_in.command_code == QAW_CODE_ANSWER;          // [RULE5]
	assign is_stop    = cmd_ok && running_reg
	                    && cmd_in.command_code == QAW_CODE_STOP;            // [RULE12]
	// restart is counted apart, so it is left out here
	assign is_other   = cmd_ok && running_reg && !is_answer && !is_stop
	                    && cmd_in.command_code != QAW_CODE_START;           // [RULE13]

	assign expected   = next_expected(prev_reg);
	assign match      = cmd_in.answer_value == expected;

	// an answer landing on the last window cycle is still on time
	assign tmo_hit    = expire && !is_answer && !is_stop;                 // [RULE10]
	assign seq_change = is_start || is_answer || tmo_hit;                 // [RULE17]
	assign cs_rise    = chip_select_n_in && !cs_n_reg;

	// ****************************************************************
	// window timer
	// ****************************************************************
	assign tmr_run = running_reg && timeout_enable_in && !wait_cs_reg;    // [RULE6]

	qaw_timer #(
		.TMO_W      (TMO_W)
	) u_timer (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.run_in     (tmr_run),
		.clear_in   (seq_change || !running_reg || is_stop),              // [RULE11]
		.limit_in   (timeout_limit_in),
		.expire_out (expire)
	);

	// chip select history for edge detection
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			cs_n_reg <= 1'b1;
		end else begin
			cs_n_reg <= chip_select_n_in;
		end
	end

	// a start or answer command holds the window until its frame ends
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wait_cs_reg <= 1'b0;
		end else if ((is_start || is_answer) && !cs_rise) begin
			wait_cs_reg <= 1'b1;                                            // [RULE2] [RULE9]
		end else if (cs_rise || !running_reg) begin
			wait_cs_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// sequence state
	// ****************************************************************
	// start and stop frame the sequence
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			running_reg <= 1'b0;
		end else if (is_start) begin
			running_reg <= 1'b1;                                            // [RULE3]
		end else if (is_stop) begin
			running_reg <= 1'b0;                                            // [RULE12]
		end
	end

	// four-bit counter wraps after sixteen values
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || is_stop) begin
			seq_reg  <= QAW_SEQ_RESET;                                      // [RULE17]
			prev_reg <= QAW_PREV_RESET;
		end else if (seq_change) begin
			seq_reg  <= seq_reg + 4'h1;                                     // [RULE22]
			prev_reg <= expected;                                           // [RULE21]
		end
	end

	// ****************************************************************
	// error accumulation counter
	// ****************************************************************
	always_comb begin
		err_inc = 2'b00;
		if ((is_start || is_answer) && !match) begin
			err_inc = 2'b01;                                                // [RULE3] [RULE7]
		end
		if (is_restart || is_other) begin
			err_inc = 2'b01;                                                // [RULE4] [RULE13]
		end
		if (tmo_hit) begin
			err_inc = err_inc + 2'b01;                                      // [RULE10]
		end
	end

	// software clear of the limit flag also empties the counter
	assign err_base = clear_in.error_limit_clear ? QAW_ERR_RESET : err_reg;  // [RULE20]

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			err_reg <= QAW_ERR_RESET;
		end else if (is_start) begin
			err_reg <= err_add(QAW_ERR_RESET, err_inc);                     // [RULE18]
		end else if (is_answer && match && !tmo_hit && err_base < QAW_ERR_LIMIT
		             && (!flags_reg.error_limit_flag || clear_in.error_limit_clear)) begin
			err_reg <= QAW_ERR_RESET;                                       // [RULE19] [RULE6]
		end else begin
			err_reg <= err_add(err_base, err_inc);                          // [RULE24]
		end
	end

	// ****************************************************************
	// sticky flags, set wins over clear
	// ****************************************************************
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			flags_reg <= '0;
		end else begin
			flags_reg.wrong_answer_flag <= ((is_start || is_answer) && !match)
				|| (flags_reg.wrong_answer_flag && !clear_in.wrong_answer_clear);  // [RULE14]
			flags_reg.late_answer_flag  <= tmo_hit
				|| (flags_reg.late_answer_flag && !clear_in.late_answer_clear);    // [RULE15]
			flags_reg.error_limit_flag  <= (err_add(err_base, err_inc) == QAW_ERR_LIMIT
				&& !is_start && !(is_answer && match && err_base < QAW_ERR_LIMIT
				&& !flags_reg.error_limit_flag))
				|| (flags_reg.error_limit_flag && !clear_in.error_limit_clear);    // [RULE16]
		end
	end

	// diagnostic follows the next flag values so it lines up with them
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			diag_n_reg <= 1'b1;
		end else begin
			diag_n_reg <= !(((is_start || is_answer) && !match) || tmo_hit
				|| (err_add(err_base, err_inc) == QAW_ERR_LIMIT && !is_start
				&& !(is_answer && match && err_base < QAW_ERR_LIMIT
				&& !flags_reg.error_limit_flag))
				|| (flags_reg.wrong_answer_flag && !clear_in.wrong_answer_clear)
				|| (flags_reg.late_answer_flag && !clear_in.late_answer_clear)
				|| (flags_reg.error_limit_flag && !clear_in.error_limit_clear));  // [RULE23]
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign flags_out         = flags_reg;
	assign diag_n_out        = diag_n_reg;
	assign running_out       = running_reg;
	assign seq_count_out     = seq_reg;
	assign prev_expected_out = prev_reg;
	assign error_count_out   = err_reg;

	// ****************************************************************
	// assertions
	// ****************************************************************
	diag_follows_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(flags_reg != '0) == !diag_n_reg)                                  // [RULE23]
		else $error("diagnostic output disagrees with flags");

	start_idle_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_start |=> running_reg && seq_reg == 4'h1 && err_reg <= 3'h1)    // [RULE1]
		else $error("start from idle did not open sequence one");

	start_wrong_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_start && !match |=> err_reg == 3'h1 && flags_reg.wrong_answer_flag)  // [RULE3]
		else $error("wrong start value not counted");

	restart_err_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_restart && !tmo_hit && !clear_in.error_limit_clear
		|=> seq_reg == $past(seq_reg) && err_reg == err_add($past(err_reg), 2'b01))  // [RULE4]
		else $error("repeated start not discarded as error");

	idle_answer_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		cmd_ok && !running_reg && cmd_in.command_code == QAW_CODE_ANSWER
		&& !clear_in.error_limit_clear
		|=> !running_reg && seq_reg == QAW_SEQ_RESET && $stable(err_reg))    // [RULE5]
		else $error("answer while idle had an effect");

	bad_crc_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		cmd_in.valid && !cmd_in.crc_ok && !tmo_hit && !clear_in.error_limit_clear
		|=> $stable(seq_reg) && $stable(err_reg))                          // [RULE8]
		else $error("failed frame changed watchdog state");

	wrong_answer_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_answer && !match |=> flags_reg.wrong_answer_flag
		&& seq_reg == $past(seq_reg) + 4'h1)                               // [RULE7]
		else $error("wrong answer not flagged or not advanced");

	timeout_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		tmo_hit |=> flags_reg.late_answer_flag && seq_reg == $past(seq_reg) + 4'h1)  // [RULE10]
		else $error("timeout not flagged or not advanced");

	stop_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_stop |=> !running_reg && seq_reg == QAW_SEQ_RESET ##1 !expire)  // [RULE12]
		else $error("stop did not end the sequence");

	other_code_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		is_other && !tmo_hit |=> $stable(seq_reg))                         // [RULE13]
		else $error("unknown code advanced the sequence");

	limit_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		err_reg == QAW_ERR_LIMIT |-> flags_reg.error_limit_flag && err_reg <= QAW_ERR_LIMIT)  // [RULE16]
		else $error("error limit reached without flag");

	limit_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		clear_in.error_limit_clear && !is_start |=> err_reg <= 3'h2)       // [RULE20]
		else $error("limit clear left the error counter");

	window_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wait_cs_reg && !cs_rise |=> !expire)                               // [RULE2]
		else $error("window ran before chip select rose");

endmodule

// file: core/qaw_pkg.sv
// qaw_pkg: constants and carrier types of the question-answer watchdog
package qaw_pkg;

	// ****************************************************************
	// command codes of the answer-entry field
	// ****************************************************************
	localparam logic [3:0] QAW_CODE_START  = 4'ha;  // begins a sequence
	localparam logic [3:0] QAW_CODE_ANSWER = 4'h7;  // delivers one answer
	localparam logic [3:0] QAW_CODE_STOP   = 4'h5;  // ends a sequence

	// ****************************************************************
	// expected-answer generator and counters
	// ****************************************************************
	localparam logic [3:0] QAW_PREV_RESET  = 4'hf;  // previous expected value when idle
	localparam logic [3:0] QAW_POLY_TAPS   = 4'h9;  // x^4+x^3+1, feedback mask
	localparam int         QAW_STEP_SHIFTS = 4;     // shifts per expected value
	localparam logic [3:0] QAW_SEQ_RESET   = 4'h0;  // sequence counter when idle
	localparam logic [2:0] QAW_ERR_LIMIT   = 3'h4;  // error counter ceiling
	localparam logic [2:0] QAW_ERR_RESET   = 3'h0;  // error counter cleared value

	// one command as it leaves the serial port at the end of a frame
	typedef struct packed {
		logic       valid;   // one-cycle strobe, frame had the right length
		logic       crc_ok;  // frame passed its check
		logic [3:0] command_code;
		logic [3:0] answer_value;
	} qaw_cmd_s;

	// software clear strobes for the sticky flags
	typedef struct packed {
		logic wrong_answer_clear;
		logic late_answer_clear;
		logic error_limit_clear;
	} qaw_clr_s;

	// sticky flag group
	typedef struct packed {
		logic wrong_answer_flag;
		logic late_answer_flag;
		logic error_limit_flag;
	} qaw_flags_s;

endpackage

// file: core/qaw_timer.sv
// qaw_timer: answer window counter of the question-answer watchdog
module qaw_timer
	import qaw_pkg::*;
#(
	parameter int TMO_W = 16  // width of the window count
) (
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             run_in,     // count this cycle
	input  wire logic             clear_in,   // restart measurement
	input  wire logic [TMO_W-1:0] limit_in,   // window length in cycles
	output logic                  expire_out  // one-cycle pulse at window end
);

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	if (TMO_W < 2 || TMO_W > 31) begin : g_bad_width
		$error("qaw_timer: TMO_W out of range");
	end

	logic [TMO_W-1:0] cnt_reg;    // cycles spent in the window
	logic [TMO_W-1:0] limit_m1;   // last cycle inside the window

	// a zero limit would wrap to the longest window; treat it as one cycle
	assign limit_m1 = (limit_in == '0) ? '0 : limit_in - TMO_W'(1);

	// ****************************************************************
	// window counter
	// ****************************************************************
	// counter holds while not running, so a stalled window resumes
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in || clear_in) begin
			cnt_reg <= '0;
		end else if (run_in && cnt_reg != limit_m1) begin
			cnt_reg <= cnt_reg + TMO_W'(1);
		end
	end

	// the owner clears the counter right after the pulse, so it fires once
	// kept free of clear_in: the owner builds its clear from this pulse,
	// and gating here would close a combinational loop through it
	assign expire_out = run_in && (cnt_reg == limit_m1);

endmodule

// file: dv/qaw_host.sv
// qaw_host: behavioural host that frames watchdog commands
module qaw_host
	import qaw_pkg::*;
(
	input  wire logic mclk_in,
	output qaw_cmd_s  cmd_out,  // decoded write frame
	output logic      cs_n_out  // serial chip select
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// idle port
	// ****************************************************************
	initial begin
		cmd_out = '0;
		cs_n_out = 1'b1;
	end

	// one frame: chip select low for gap cycles, strobe with the rise
	// tail keeps chip select low that many cycles past the strobe
	// fields are inverted once released so stale values never match
	task automatic send(input logic [3:0] code, input logic [3:0] val,
			input logic ok, input int gap, input int tail);
		@(negedge mclk_in);
		cs_n_out = 1'b0;
		repeat (gap) @(negedge mclk_in);
		cmd_out = '{1'b1, ok, code, val};  // strobe carries the given code and value
		if (tail == 0) begin
			cs_n_out = 1'b1;  // no tail: chip select rises with the strobe
		end
		@(negedge mclk_in);
		cmd_out = '{1'b0, ~ok, ~code, ~val};
		// late frame end: the window must wait for this rise
		if (tail > 0) begin
			repeat (tail - 1) @(negedge mclk_in);
			cs_n_out = 1'b1;
		end
	endtask
endmodule

// file: dv/tb.sv
// tb: self-checking bench of the question-answer watchdog
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb
	import qaw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int LIM = 8;  // short window keeps the run brief
	logic        mclk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        timeout_enable_in = 1'b0;
	logic [15:0] timeout_limit_in = 16'h0008;
	qaw_clr_s    clear_in = '0;
	qaw_cmd_s    cmd;
	logic        cs_n;
	qaw_flags_s  flags;
	logic        diag_n;
	logic        running;
	logic [3:0]  seq;
	logic [3:0]  prev;
	logic [2:0]  err;
	logic [3:0]  ep;  // expected previous value
	int          fail_count = 0;
	int          comparisons = 0;

	always #2.5 mclk_in = ~mclk_in;

	qaw_host host (.mclk_in(mclk_in), .cmd_out(cmd), .cs_n_out(cs_n));

	qaw_watchdog uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd),
		.chip_select_n_in(cs_n), .timeout_enable_in(timeout_enable_in),
		.timeout_limit_in(timeout_limit_in), .clear_in(clear_in), .flags_out(flags),
		.diag_n_out(diag_n), .running_out(running), .seq_count_out(seq),
		.prev_expected_out(prev), .error_count_out(err));

	// ****************************************************************
	// helpers
	// ****************************************************************
	// four galois shifts, written apart from the design on purpose
	function automatic logic [3:0] nx(input logic [3:0] x);
		for (int i = 0; i < 4; i++) begin
			x = x[3] ? ({x[2:0], 1'b0} ^ 4'h9) : {x[2:0], 1'b0};
		end
		return x;
	endfunction

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic send(input logic [3:0] c, input logic [3:0] v, input logic ok = 1'b1);
		host.send(c, v, ok, 2, 0);
	endtask

	task automatic st(input logic [3:0] s, input logic [3:0] p, input logic [2:0] e);
		`CHK(seq, s)
		`CHK(prev, p)
		`CHK(err, e)
	endtask

	// one-cycle clear pulse
	task automatic clr(input qaw_clr_s c);
		@(negedge mclk_in);
		clear_in = c;
		@(negedge mclk_in);
		clear_in = '0;
	endtask

	// bounded wait for the sequence counter to move
	task automatic wait_seq(output int n);
		logic [3:0] s;
		s = seq;
		n = 0;
		while (seq === s && n < 200) begin
			@(negedge mclk_in);
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			close_out();
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// answer, stop and stray code while idle leave no trace
	task automatic t_idle;
		send(QAW_CODE_ANSWER, 4'ha);
		send(QAW_CODE_STOP, 4'h0);
		send(4'h3, 4'ha);
		`CHK(running, 1'b0)
		st(4'h0, 4'hf, 3'h0);
	endtask

	// wrong start value, repeat start, stray code, good answer, bad frame
	task automatic t_start;
		send(QAW_CODE_START, 4'h3);
		ep = 4'ha;
		`CHK(running, 1'b1)
		st(4'h1, ep, 3'h1);
		`CHK(flags, 3'h4)
		`CHK(diag_n, 1'b0)
		send(QAW_CODE_START, 4'ha);
		st(4'h1, ep, 3'h2);
		send(4'h3, 4'h0);
		st(4'h1, ep, 3'h3);
		ep = nx(ep);
		send(QAW_CODE_ANSWER, ep);
		st(4'h2, ep, 3'h0);
		send(QAW_CODE_ANSWER, nx(ep), 1'b0);
		st(4'h2, ep, 3'h0);
	endtask

	// wrong answers up to and past the limit, then the clears
	task automatic t_limit;
		for (int i = 1; i <= 5; i++) begin
			ep = nx(ep);
			send(QAW_CODE_ANSWER, ~ep);
			`CHK(err, (i < 4) ? 3'(i) : 3'h4)
			`CHK(seq, 4'(2 + i))
		end
		`CHK(flags, 3'h5)
		ep = nx(ep);
		send(QAW_CODE_ANSWER, ep);
		st(4'h8, ep, 3'h4);
		clr('{1'b0, 1'b0, 1'b1});
		`CHK(err, 3'h0)
		`CHK(flags, 3'h4)
		clr('{1'b1, 1'b0, 1'b0});
		`CHK(diag_n, 1'b1)
	endtask

	// sixteen good answers bring the counter round again
	task automatic t_wrap;
		for (int i = 0; i < 16; i++) begin
			ep = nx(ep);
			send(QAW_CODE_ANSWER, ep);
			`CHK(prev, ep)
		end
		st(4'h8, ep, 3'h0);
	endtask

	// stop keeps the error count, then an answer is ignored while idle
	task automatic t_stop;
		send(4'h1, 4'h0);
		send(QAW_CODE_STOP, 4'h9);
		`CHK(running, 1'b0)
		st(4'h0, 4'hf, 3'h1);
		send(QAW_CODE_ANSWER, 4'ha);
		st(4'h0, 4'hf, 3'h1);
	endtask

	// two missed windows, a prompt answer, a late frame end, then timing off
	task automatic t_timeout;
		int n;
		timeout_enable_in = 1'b1;
		send(QAW_CODE_START, 4'ha);
		ep = 4'ha;
		st(4'h1, ep, 3'h0);
		wait_seq(n);
		`CHK(n, LIM)
		ep = nx(ep);
		st(4'h2, ep, 3'h1);
		`CHK(flags, 3'h2)
		wait_seq(n);
		`CHK(n, LIM)
		ep = nx(ep);
		st(4'h3, ep, 3'h2);
		ep = nx(ep);
		send(QAW_CODE_ANSWER, ep);
		st(4'h4, ep, 3'h0);
		// chip select rises three cycles after the strobe: window starts there
		ep = nx(ep);
		host.send(QAW_CODE_ANSWER, ep, 1'b1, 2, 3);
		st(4'h5, ep, 3'h0);
		wait_seq(n);
		`CHK(n, LIM + 1)
		ep = nx(ep);
		st(4'h6, ep, 3'h1);
		timeout_enable_in = 1'b0;
		repeat (3 * LIM) @(negedge mclk_in);
		`CHK(seq, 4'h6)
		clr('{1'b0, 1'b1, 1'b0});
		`CHK(flags, 3'h0)
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (6) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		t_idle();
		t_start();
		t_limit();
		t_wrap();
		t_stop();
		t_timeout();
		close_out();
	end
endmodule
